// ### rtl/ssfs_pkg.sv
// Package for the receive capture and memory segment sequencer.
// Assumes one system clock and a synchronous, active-high reset.
`default_nettype none
package ssfs_pkg;
    // ************************************************************
    // Register offsets (byte addresses).
    // ************************************************************
    localparam logic [7:0] SSFS_OFS_RX_CTRL = 8'h34;
    localparam logic [7:0] SSFS_OFS_RX_STAT = 8'h38;
    localparam logic [7:0] SSFS_OFS_RX_A = 8'h50;
    localparam logic [7:0] SSFS_OFS_TX_A = 8'h54;
    localparam logic [7:0] SSFS_OFS_SET_MEM = 8'h58;
    localparam logic [7:0] SSFS_OFS_RX_B = 8'h5c;
    localparam logic [7:0] SSFS_OFS_TX_B = 8'h60;
    localparam logic [7:0] SSFS_OFS_RX_C = 8'h64;
    localparam logic [7:0] SSFS_OFS_TX_C = 8'h68;
    localparam logic [7:0] SSFS_OFS_RX_D = 8'h6c;
    localparam logic [7:0] SSFS_OFS_TX_D = 8'h70;
    localparam logic [7:0] SSFS_OFS_RX_LOOP = 8'h74;
    localparam logic [7:0] SSFS_OFS_TX_LOOP = 8'h78;
    localparam logic [7:0] SSFS_OFS_RX_CMD = 8'h7c;
    localparam logic [7:0] SSFS_OFS_TX_CMD = 8'h80;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int SSFS_CTL_RX_EN = 0;
    localparam int SSFS_CTL_LOOP_IRQ = 2;
    localparam int SSFS_CTL_AF_IRQ = 3;
    localparam int SSFS_CTL_OVF_IRQ = 4;
    localparam int SSFS_CTL_LOAD = 8;
    localparam int SSFS_CTL_UNLOAD = 9;
    localparam logic [31:0] SSFS_CTL_MASK = 32'h0000_031d;
    localparam int SSFS_CMD_TEST = 0;
    localparam int SSFS_CMD_LOOPED = 2;
    localparam int SSFS_CMD_CONT = 3;
    localparam logic [7:0] SSFS_CMD_MASK = 8'h0d;
    localparam int SSFS_ST_OVF = 0;
    localparam int SSFS_ST_AF = 1;
    localparam int SSFS_ST_LOOP = 2;

    // ************************************************************
    // Values after reset, sizes and levels.
    // ************************************************************
    localparam logic [31:0] SSFS_RST_WORD = 32'h0000_0000;
    localparam logic [7:0] SSFS_RST_BYTE = 8'h00;
    localparam int SSFS_AW = 24;
    localparam logic [23:0] SSFS_AF_LEVEL = 24'h0001f0;
    localparam logic [1:0] SSFS_BUF_DEPTH = 2'h2;

    // ************************************************************
    // Memory sequencer states, Gray along the read path.
    // ************************************************************
    typedef enum logic [2:0] {
        SSFS_IDLE = 3'h0,
        SSFS_WR_LO = 3'h1,
        SSFS_WR_HI = 3'h3,
        SSFS_RD_LO = 3'h2,
        SSFS_RD_HI = 3'h6,
        SSFS_DMA_OUT = 3'h4
    } ssfs_state_t;
endpackage
`default_nettype wire

// ### rtl/ssfs_sequencer.sv
// Receive capture, two-word IO buffer and memory segment sequencer.
// Assumes a memory port that grants one 16-bit access per mem_gnt and
// a link clock far slower than clk_sys.
//
// Overview of operation
// - Receive enable starts capture; clear means idle.
// - Byte captured on falling link clock with enable.
// - Bytes packed into words, first byte lowest.
// - Capture continues until receive enable cleared.
// - Loop completion interrupt gated by its enable.
// - Almost-full flag drives interrupt when enabled.
// - Full at word write sets sticky overflow.
// - IO buffer drains to memory without software.
// - Load and unload enables act independently.
// - Start and end pointers are inclusive.
// - Each address is one 16-bit location.
// - B and C bound the body.
// - Looped: A to C, repeat body, on to D.
// - Eight-bit loop count, values 1 to 255.
// - D included; FIFO mode wraps to A.
// - Retransmit: after D wrap or stop.
// - Receive keeps its own data counter.
// - Command bits: continuous, looped, test.
// - Looped select applies count, else FIFO.
// - Continuous repeats pattern, else once.
// - FIFO mode always runs continuously.
`default_nettype none
module ssfs_sequencer
    import ssfs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic irq,
    // Link from the data source
    input wire logic link_clk,
    input wire logic link_en,
    input wire logic [7:0] link_data,
    // Memory port
    output logic mem_req,
    output logic mem_we,
    output logic [ssfs_pkg::SSFS_AW-1:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic mem_gnt,
    input wire logic [15:0] mem_rdata,
    // DMA FIFO side
    output logic dma_valid,
    output logic [31:0] dma_data,
    input wire logic dma_ready
);
    import ssfs_pkg::*;

    // ************************************************************
    // Registers.
    // ************************************************************
    logic [31:0] ctrl_q, rx_a_q, tx_a_q, set_mem_q, rx_b_q, tx_b_q;
    logic [31:0] rx_c_q, tx_c_q, rx_d_q, tx_d_q;
    logic [7:0] rx_loop_q, tx_loop_q, rx_cmd_q, tx_cmd_q;
    logic ovf_q, loop_done_q, af_q;
    logic ovf_set, loop_set;
    logic rx_en, load_en, unload_en, looped, cont;

    assign rx_en = ctrl_q[SSFS_CTL_RX_EN];
    assign load_en = ctrl_q[SSFS_CTL_LOAD];
    assign unload_en = ctrl_q[SSFS_CTL_UNLOAD];
    assign looped = rx_cmd_q[SSFS_CMD_LOOPED];
    assign cont = rx_cmd_q[SSFS_CMD_CONT];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= SSFS_RST_WORD;
            rx_a_q <= SSFS_RST_WORD;
            tx_a_q <= SSFS_RST_WORD;
            set_mem_q <= SSFS_RST_WORD;
            rx_b_q <= SSFS_RST_WORD;
            tx_b_q <= SSFS_RST_WORD;
            rx_c_q <= SSFS_RST_WORD;
            tx_c_q <= SSFS_RST_WORD;
            rx_d_q <= SSFS_RST_WORD;
            tx_d_q <= SSFS_RST_WORD;
            rx_loop_q <= SSFS_RST_BYTE;
            tx_loop_q <= SSFS_RST_BYTE;
            rx_cmd_q <= SSFS_RST_BYTE;
            tx_cmd_q <= SSFS_RST_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                SSFS_OFS_RX_CTRL: ctrl_q <= reg_wdata & SSFS_CTL_MASK;
                SSFS_OFS_RX_A: rx_a_q <= reg_wdata;
                SSFS_OFS_TX_A: tx_a_q <= reg_wdata;
                SSFS_OFS_SET_MEM: set_mem_q <= reg_wdata;
                SSFS_OFS_RX_B: rx_b_q <= reg_wdata;
                SSFS_OFS_TX_B: tx_b_q <= reg_wdata;
                SSFS_OFS_RX_C: rx_c_q <= reg_wdata;
                SSFS_OFS_TX_C: tx_c_q <= reg_wdata;
                SSFS_OFS_RX_D: rx_d_q <= reg_wdata;
                SSFS_OFS_TX_D: tx_d_q <= reg_wdata;
                SSFS_OFS_RX_LOOP: rx_loop_q <= reg_wdata[7:0];
                SSFS_OFS_TX_LOOP: tx_loop_q <= reg_wdata[7:0];
                SSFS_OFS_RX_CMD: rx_cmd_q <= reg_wdata[7:0] & SSFS_CMD_MASK;
                SSFS_OFS_TX_CMD: tx_cmd_q <= reg_wdata[7:0] & SSFS_CMD_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= SSFS_RST_WORD;
        end else if (reg_rd) begin
            case (reg_addr)
                SSFS_OFS_RX_CTRL: reg_rdata <= ctrl_q;
                SSFS_OFS_RX_STAT: reg_rdata <= {29'h0, loop_done_q, af_q, ovf_q};
                SSFS_OFS_RX_A: reg_rdata <= rx_a_q;
                SSFS_OFS_TX_A: reg_rdata <= tx_a_q;
                SSFS_OFS_SET_MEM: reg_rdata <= set_mem_q;
                SSFS_OFS_RX_B: reg_rdata <= rx_b_q;
                SSFS_OFS_TX_B: reg_rdata <= tx_b_q;
                SSFS_OFS_RX_C: reg_rdata <= rx_c_q;
                SSFS_OFS_TX_C: reg_rdata <= tx_c_q;
                SSFS_OFS_RX_D: reg_rdata <= rx_d_q;
                SSFS_OFS_TX_D: reg_rdata <= tx_d_q;
                SSFS_OFS_RX_LOOP: reg_rdata <= {24'h0, rx_loop_q};
                SSFS_OFS_TX_LOOP: reg_rdata <= {24'h0, tx_loop_q};
                SSFS_OFS_RX_CMD: reg_rdata <= {24'h0, rx_cmd_q};
                SSFS_OFS_TX_CMD: reg_rdata <= {24'h0, tx_cmd_q};
                default: reg_rdata <= SSFS_RST_WORD;
            endcase
        end
    end

    // ************************************************************
    // Status flags and interrupt request.
    // ************************************************************
    // Sticky overflow, set beats clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else if (ovf_set) begin
            ovf_q <= 1'b1;
        end else if (reg_wr && reg_addr == SSFS_OFS_RX_STAT && reg_wdata[SSFS_ST_OVF]) begin
            ovf_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            loop_done_q <= 1'b0;
        end else if (loop_set) begin
            loop_done_q <= 1'b1;
        end else if (reg_wr && reg_addr == SSFS_OFS_RX_STAT && reg_wdata[SSFS_ST_LOOP]) begin
            loop_done_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= (ovf_q & ctrl_q[SSFS_CTL_OVF_IRQ])
                | (af_q & ctrl_q[SSFS_CTL_AF_IRQ])
                | (loop_done_q & ctrl_q[SSFS_CTL_LOOP_IRQ]);
        end
    end

    // ************************************************************
    // Link synchronisers and byte capture.
    // ************************************************************
    logic [9:0] sync1_q, sync2_q;
    logic clk_old_q;
    logic [31:0] pack_q;
    logic [1:0] byte_idx_q;
    logic word_stb_q;
    logic buf_in_ready;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_q <= 10'h000;
            sync2_q <= 10'h000;
            clk_old_q <= 1'b0;
        end else begin
            sync1_q <= {link_clk, link_en, link_data};
            sync2_q <= sync1_q;
            clk_old_q <= sync2_q[9];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || !rx_en) begin
            pack_q <= SSFS_RST_WORD;
            byte_idx_q <= 2'h0;
            word_stb_q <= 1'b0;
        end else begin
            word_stb_q <= 1'b0;
            if (clk_old_q && !sync2_q[9] && sync2_q[8]) begin
                pack_q[byte_idx_q*8 +: 8] <= sync2_q[7:0];
                byte_idx_q <= byte_idx_q + 2'h1;
                word_stb_q <= (byte_idx_q == 2'h3);
            end
        end
    end

    // Word arriving at a full path
    assign ovf_set = word_stb_q && !buf_in_ready;

    // ************************************************************
    // Two-entry IO buffer.
    // ************************************************************
    logic [31:0] buf_mem_q [2];
    logic buf_wp_q, buf_rp_q;
    logic [1:0] buf_cnt_q;
    logic buf_pop, buf_push;

    assign buf_in_ready = (buf_cnt_q != SSFS_BUF_DEPTH);
    assign buf_push = word_stb_q && buf_in_ready;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            buf_wp_q <= 1'b0;
            buf_rp_q <= 1'b0;
            buf_cnt_q <= 2'h0;
        end else begin
            if (buf_push) begin
                buf_mem_q[buf_wp_q] <= pack_q;
                buf_wp_q <= ~buf_wp_q;
            end
            if (buf_pop) begin
                buf_rp_q <= ~buf_rp_q;
            end
            buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    // ************************************************************
    // Segment pointers.
    // ************************************************************
    logic [23:0] wa_q, ra_q, avail_q, cap;
    logic [7:0] wl_q, rl_q;
    logic wstop_q, rstop_q;
    logic [33:0] wnext, rnext;
    ssfs_state_t state_q;
    logic [15:0] rd_lo_q;
    logic wr_done, rd_done;

    // Inclusive bounds, two locations a word
    assign cap = 24'((rx_d_q[23:0] - rx_a_q[23:0] + 24'h1) >> 1);

    // Returns {stop, loop-done, remaining count, next address}.
    function automatic logic [33:0] ssfs_step(input logic [23:0] a, input logic [7:0] left);
        logic [23:0] last;
        last = a + 24'h1;
        if (looped && last == rx_c_q[23:0] && left > 8'h1) begin
            return {2'b00, 8'(left - 8'h1), rx_b_q[23:0]};
        end else if (last == rx_d_q[23:0]) begin
            if (!looped) begin
                return {2'b00, left, rx_a_q[23:0]};
            end else if (cont) begin
                return {2'b01, rx_loop_q, rx_a_q[23:0]};
            end else begin
                return {2'b11, left, a};
            end
        end else begin
            return {2'b00, left, 24'(a + 24'h2)};
        end
    endfunction

    assign wnext = ssfs_step(wa_q, wl_q);
    assign rnext = ssfs_step(ra_q, rl_q);
    assign wr_done = (state_q == SSFS_WR_HI) && mem_gnt;
    assign rd_done = (state_q == SSFS_DMA_OUT) && dma_ready;
    // Buffer drains on each completed word write
    assign buf_pop = wr_done;
    assign loop_set = (wr_done && wnext[32]) || (wr_done && wnext[33]);

    // Load pointer follows load enable only
    always_ff @(posedge clk_sys) begin
        if (rst || !load_en) begin
            wa_q <= rx_a_q[23:0];
            wl_q <= rx_loop_q;
            wstop_q <= 1'b0;
        end else if (wr_done) begin
            wa_q <= wnext[23:0];
            wl_q <= wnext[31:24];
            wstop_q <= wnext[33];
        end
    end

    // Unload pointer follows unload enable only
    always_ff @(posedge clk_sys) begin
        if (rst || !unload_en) begin
            ra_q <= rx_a_q[23:0];
            rl_q <= rx_loop_q;
            rstop_q <= 1'b0;
        end else if (rd_done) begin
            ra_q <= rnext[23:0];
            rl_q <= rnext[31:24];
            rstop_q <= rnext[33];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avail_q <= 24'h0;
            af_q <= 1'b0;
        end else begin
            avail_q <= avail_q + {23'h0, wr_done} - {23'h0, rd_done};
            af_q <= (avail_q >= SSFS_AF_LEVEL);
        end
    end

    // ************************************************************
    // Memory sequencer.
    // ************************************************************
    // Loading wins over unloading so the capture path backs up last.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= SSFS_IDLE;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 24'h0;
            mem_wdata <= 16'h0;
            rd_lo_q <= 16'h0;
            dma_valid <= 1'b0;
            dma_data <= SSFS_RST_WORD;
        end else begin
            case (state_q)
                SSFS_IDLE: begin
                    if (load_en && !wstop_q && buf_cnt_q != 2'h0
                        && (looped || avail_q < cap)) begin
                        state_q <= SSFS_WR_LO;
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= wa_q;
                        mem_wdata <= buf_mem_q[buf_rp_q][15:0];
                    // Looped unload trusts a loaded pattern
                    end else if (unload_en && !rstop_q && (looped || avail_q != 24'h0)) begin
                        state_q <= SSFS_RD_LO;
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_addr <= ra_q;
                    end
                end
                SSFS_WR_LO: begin
                    if (mem_gnt) begin
                        state_q <= SSFS_WR_HI;
                        mem_addr <= 24'(mem_addr + 24'h1);
                        mem_wdata <= buf_mem_q[buf_rp_q][31:16];
                    end
                end
                SSFS_WR_HI: begin
                    if (mem_gnt) begin
                        state_q <= SSFS_IDLE;
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                    end
                end
                SSFS_RD_LO: begin
                    if (mem_gnt) begin
                        state_q <= SSFS_RD_HI;
                        rd_lo_q <= mem_rdata;
                        mem_addr <= 24'(mem_addr + 24'h1);
                    end
                end
                SSFS_RD_HI: begin
                    if (mem_gnt) begin
                        state_q <= SSFS_DMA_OUT;
                        mem_req <= 1'b0;
                        dma_valid <= 1'b1;
                        dma_data <= {mem_rdata, rd_lo_q};
                    end
                end
                SSFS_DMA_OUT: begin
                    if (dma_ready) begin
                        state_q <= SSFS_IDLE;
                        dma_valid <= 1'b0;
                    end
                end
                default: begin
                    state_q <= SSFS_IDLE;
                    mem_req <= 1'b0;
                    dma_valid <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### verif/ssfs_seq_asserts.sv
// Port checker for the receive capture and memory sequencer.
// Assumes it is bound to each ssfs_sequencer and sees only its ports.
`default_nettype none
module ssfs_seq_asserts
    import ssfs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic irq,
    // Memory and DMA side
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [ssfs_pkg::SSFS_AW-1:0] mem_addr,
    input wire logic mem_gnt,
    input wire logic dma_valid,
    input wire logic [31:0] dma_data,
    input wire logic dma_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] ctl_q;
    logic seen_en_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Shadow of the control register, since the checker cannot see inside.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctl_q <= 32'h0;
            seen_en_q <= 1'b0;
        end else if (reg_wr && reg_addr == SSFS_OFS_RX_CTRL) begin
            ctl_q <= reg_wdata;
            seen_en_q <= seen_en_q | reg_wdata[SSFS_CTL_RX_EN];
        end
    end
    reset_idle_a: assert property (disable iff (1'b0)
        rst |=> !mem_req && !dma_valid && !irq) else $error("outputs busy after reset");
    req_hold_a: assert property (
        mem_req && !mem_gnt |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before grant");
    half_step_a: assert property (
        mem_req && mem_gnt && !mem_addr[0] |=> mem_req && mem_addr == $past(mem_addr) + 1'b1)
        else $error("upper half not at next location");
    pair_end_a: assert property (
        mem_req && mem_gnt && mem_addr[0] |=> !mem_req) else $error("no idle after word");
    dma_hold_a: assert property (
        dma_valid && !dma_ready |=> dma_valid && $stable(dma_data))
        else $error("dma word dropped while stalled");
    irq_mask_a: assert property (
        ctl_q[4:2] == 3'h0 && $past(ctl_q[4:2]) == 3'h0 |-> !irq)
        else $error("interrupt with all enables clear");
    rx_off_a: assert property (
        !seen_en_q |-> !(mem_req && mem_we)) else $error("store before capture enabled");
    load_gate_a: assert property (
        $rose(mem_req) && mem_we |-> ctl_q[SSFS_CTL_LOAD] || $past(ctl_q[SSFS_CTL_LOAD]))
        else $error("store without load enable");
    unload_gate_a: assert property (
        $rose(mem_req) && !mem_we |-> ctl_q[SSFS_CTL_UNLOAD] || $past(ctl_q[SSFS_CTL_UNLOAD]))
        else $error("fetch without unload enable");
    cmd_spare_a: assert property (
        reg_rd && reg_addr == SSFS_OFS_RX_CMD |=> reg_rdata[31:4] == 28'h0 && !reg_rdata[1])
        else $error("command spare bits not zero");
endmodule
bind ssfs_sequencer ssfs_seq_asserts ssfs_seq_asserts_i (.clk_sys, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .irq, .mem_req, .mem_we, .mem_addr, .mem_gnt,
    .dma_valid, .dma_data, .dma_ready);
`default_nettype wire

// ### verif/ssfs_link_src.sv
// Model of the byte source on the receive link.
// Assumes one bench process calls beat at a time.
`default_nettype none
module ssfs_link_src (
    // Link pins
    output logic link_clk,
    output logic link_en,
    output logic [7:0] link_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        link_clk = 1'b1;
        link_en = 1'b0;
        link_data = 8'h5a;
    end
    always #160 link_clk = ~link_clk;
    // Change on the rising edge so the falling edge finds settled data.
    // An idle beat shows the inverse of the last byte, never a stale copy.
    task automatic beat(input logic en, input logic [7:0] d);
        @(posedge link_clk);
        link_en = en;
        link_data = en ? d : ~link_data;
    endtask
endmodule
`default_nettype wire

// ### verif/ssfs_sequencer_tb.sv
// Self-checking bench for the receive sequencer, with memory and DMA models.
// Assumes the link source model and the bound port checker.
`default_nettype none
module ssfs_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ssfs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, dma_data, w;
    logic irq, link_clk, link_en, mem_req, mem_we, dma_valid;
    logic mem_gnt = 1'b0;
    logic dma_ready = 1'b0;
    logic hi_half = 1'b0;
    logic [7:0] link_data;
    logic [SSFS_AW-1:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata = 16'h0;
    logic [15:0] mem_m [int];
    logic [31:0] exp_w [$];
    logic [31:0] exp_d [$];
    int seed = 32'he024e501;
    int fails = 0;
    int compares = 0;
    int nwr = 0;
    int wa = 'h10;
    int seg_a = 'h10;
    int seg_d = 'h17;
    int seg_c = -1;
    int reps = 0;
    always #20 clk_sys = ~clk_sys;
    ssfs_link_src ssfs_link_src_i (.link_clk, .link_en, .link_data);
    ssfs_sequencer ssfs_sequencer_i (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .irq, .link_clk, .link_en, .link_data, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_gnt, .mem_rdata, .dma_valid, .dma_data, .dma_ready);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic summarize;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk(reg_rdata, e, "register read");
    endtask
    task automatic send_word(input logic [31:0] d);
        for (int i = 0; i < 4; i++) begin
            if ($random(seed) % 2 == 0) ssfs_link_src_i.beat(1'b0, 8'h00);
            ssfs_link_src_i.beat(1'b1, d[8*i+:8]);
        end
    endtask
    task automatic drain(input bit all);
        int n = 0;
        while ((exp_w.size() != 0 || all && (exp_d.size() != 0 || dma_valid !== 1'b0))
               && n < 5000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 5000) begin
            fails++;
            summarize();
        end
    endtask
    // ************************************************************
    // Memory and DMA models: random grant delay and random stalls.
    // ************************************************************
    always @(negedge clk_sys) begin
        dma_ready <= ($random(seed) % 3) != 0;
        if (!mem_gnt && mem_req && $random(seed) % 2 == 0) begin
            mem_gnt <= 1'b1;
            mem_rdata <= mem_m.exists(int'(mem_addr)) ? mem_m[int'(mem_addr)] : ~mem_rdata;
        end else begin
            mem_gnt <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
    always @(posedge clk_sys) begin
        if (!rst && mem_req && mem_gnt && mem_we) begin
            mem_m[int'(mem_addr)] = mem_wdata;
            chk(mem_addr, wa + hi_half, "write address");
            chk(mem_wdata, hi_half ? exp_w[0][31:16] : exp_w[0][15:0], "write data");
            if (hi_half) begin
                exp_d.push_back(exp_w.pop_front());
                nwr++;
                if (wa + 1 == seg_c && reps > 1) begin
                    reps--;
                    wa = seg_c - 1;
                end else begin
                    wa = (wa + 2 > seg_d) ? seg_a : wa + 2;
                end
            end
            hi_half = !hi_half;
        end
        if (!rst && dma_valid && dma_ready) chk(dma_data, exp_d.pop_front(), "dma word");
    end
    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        rd(SSFS_OFS_RX_CTRL, 32'h0);
        rd(SSFS_OFS_RX_STAT, 32'h0);
        for (int a = 'h50; a <= 'h80; a += 4) rd(8'(a), 32'h0);
        rd(8'h90, 32'h0);
        wr(SSFS_OFS_RX_CTRL, 32'hffff_fffe);
        rd(SSFS_OFS_RX_CTRL, 32'hffff_fffe & SSFS_CTL_MASK);
        wr(SSFS_OFS_RX_CTRL, 32'h0);
        wr(SSFS_OFS_RX_CMD, 32'hff);
        rd(SSFS_OFS_RX_CMD, 32'h0d);
        wr(SSFS_OFS_RX_LOOP, 32'h1ff);
        rd(SSFS_OFS_RX_LOOP, 32'hff);
        w = $random(seed);
        wr(SSFS_OFS_TX_D, w);
        rd(SSFS_OFS_TX_D, w);
        // initialisation value first, then the real start
        wr(SSFS_OFS_RX_A, 32'h37);
        rd(SSFS_OFS_RX_A, 32'h37);
        // even start, separate segment, test bit clear
        wr(SSFS_OFS_RX_CMD, 32'h0);
        wr(SSFS_OFS_RX_A, seg_a);
        wr(SSFS_OFS_RX_D, seg_d);
        // Bytes arriving with capture off must leave no trace.
        wr(SSFS_OFS_RX_CTRL, 32'h300);
        send_word($random(seed));
        ssfs_link_src_i.beat(1'b0, 8'h00);
        repeat (40) @(negedge clk_sys);
        chk(nwr, 0, "capture while off");
        // Six words through a four-word segment, so the store wraps to A.
        wr(SSFS_OFS_RX_CTRL, 32'h301);
        repeat (6) begin
            w = $random(seed);
            exp_w.push_back(w);
            send_word(w);
        end
        ssfs_link_src_i.beat(1'b0, 8'h00);
        drain(1'b1);
        chk(nwr, 6, "words stored");
        // load held off: the third word meets a full two-entry buffer.
        wr(SSFS_OFS_RX_CTRL, 32'h011);
        wa = seg_a;
        for (int k = 0; k < 3; k++) begin
            w = $random(seed);
            if (k < 2) exp_w.push_back(w);
            send_word(w);
        end
        ssfs_link_src_i.beat(1'b0, 8'h00);
        repeat (8) @(negedge clk_sys);
        rd(SSFS_OFS_RX_STAT, 32'h1);
        chk(irq, 1'b1, "overflow interrupt");
        wr(SSFS_OFS_RX_STAT, 32'h1);
        rd(SSFS_OFS_RX_STAT, 32'h0);
        wr(SSFS_OFS_RX_CTRL, 32'h101);
        drain(1'b0);
        chk(exp_d.size(), 2, "unload held off");
        wr(SSFS_OFS_RX_CTRL, 32'h301);
        drain(1'b1);
        chk(nwr, 8, "held words stored");
        // Looped: A, a one-word body twice, then D, then stop.
        wr(SSFS_OFS_RX_CTRL, 32'h001);
        wr(SSFS_OFS_RX_CMD, 32'h04);
        wr(SSFS_OFS_RX_B, 'h12);
        wr(SSFS_OFS_RX_C, 'h13);
        wr(SSFS_OFS_RX_LOOP, 32'h2);
        seg_c = 'h13;
        reps = 2;
        wa = seg_a;
        wr(SSFS_OFS_RX_CTRL, 32'h101);
        repeat (5) begin
            w = $random(seed);
            exp_w.push_back(w);
            send_word(w);
        end
        ssfs_link_src_i.beat(1'b0, 8'h00);
        drain(1'b0);
        rd(SSFS_OFS_RX_STAT, 32'h4);
        // B was stored twice; both reads see the later word.
        exp_d[1] = exp_d[2];
        wr(SSFS_OFS_RX_CTRL, 32'h301);
        drain(1'b1);
        chk(nwr, 13, "looped words stored");
        summarize();
    end
endmodule
`default_nettype wire
